// ===== verilog/cwd_config_word_decoder.sv
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
`include "cwd_map.svh"
module cwd_config_word_decoder #(
  parameter int unsigned DELAY_CYC = `CWD_DELAY_CYC
) (
  input  wire  logic        sys_clk,
  input  wire  logic        rstn,
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output logic        [31:0] hrdata,
  output logic              hreadyout,
  output logic              hresp,
  input  wire  logic        ext_reset_in_n,
  input  wire  logic        sleep_in,
  input  wire  logic        brownout_soft_en,
  input  wire  logic        watchdog_soft_en,
  input  wire  logic        por_event,
  input  wire  logic        brownout_event,
  output logic              clock_fail_monitor_en,
  output logic              clock_switchover_en,
  output logic              brownout_reset_en,
  output logic              data_mem_protect,
  output logic              prog_mem_protect,
  output logic              data_mem_erase,
  output logic              prog_mem_erase,
  output logic              ext_reset_pin_sel,
  output logic              chip_reset_n,
  output logic              pin_io_in,
  output logic              powerup_delay_active,
  output logic              watchdog_en,
  output logic [2:0]        osc_source_sel,
  output logic              osc_clkin_used,
  output logic              osc_clkout_drive,
  output logic              osc_pins_crystal,
  output logic              internal_osc_run,
  output logic [15:0]       trim_word
);
  import cwd_pkg::*;

  // pin and async status inputs pass two flops
  logic [1:0] pin_s1_r, pin_s2_r;
  logic [1:0] evt_s1_r, evt_s2_r;
  logic       slp_s1_r, slp_s2_r;
  logic       por_d_r, brn_d_r;
  logic [15:0] cfg_r, cfg_nxt;
  logic [15:0] cal_r, cal_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic        wr_r, wr_nxt, rd_r, rd_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  cwd_state_e  st_r, st_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [1:0]  erase_r, erase_nxt;
  logic [15:0] cfg_read;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pin_s1_r <= 2'h3;
      pin_s2_r <= 2'h3;
      evt_s1_r <= 2'h0;
      evt_s2_r <= 2'h0;
      slp_s1_r <= 1'h0;
      slp_s2_r <= 1'h0;
      por_d_r  <= 1'h0;
      brn_d_r  <= 1'h0;
    end else begin
      pin_s1_r <= {ext_reset_in_n, ext_reset_in_n};
      pin_s2_r <= pin_s1_r;
      evt_s1_r <= {brownout_event, por_event};
      evt_s2_r <= evt_s1_r;
      slp_s1_r <= sleep_in;
      slp_s2_r <= slp_s1_r;
      por_d_r  <= evt_s2_r[0];
      brn_d_r  <= evt_s2_r[1];
    end
  end

  function automatic logic cwd_hit(input logic [31:0] a, input logic [31:0] base);
    cwd_hit = (a[7:2] == base[7:2]);
  endfunction

  assign cfg_read = cfg_r | `CWD_UNIMP_MASK;

  // ahb-lite slave, zero wait states, always OKAY
  always_comb begin
    addr_nxt  = addr_r;
    wr_nxt    = 1'b0;
    rd_nxt    = 1'b0;
    cfg_nxt   = cfg_r;
    cal_nxt   = cal_r;
    rdata_nxt = rdata_r;
    if (hsel && hready && htrans[1]) begin
      addr_nxt = haddr;
      wr_nxt   = hwrite;
      rd_nxt   = !hwrite;
    end
    if (wr_r) begin
      if (cwd_hit(addr_r, `CWD_CFG_ADDR)) cfg_nxt = hwdata[15:0] | `CWD_UNIMP_MASK;
      if (cwd_hit(addr_r, `CWD_CAL_ADDR)) cal_nxt = hwdata[15:0];
    end
    if (hsel && hready && htrans[1] && !hwrite) begin
      if (cwd_hit(haddr, `CWD_CFG_ADDR))       rdata_nxt = {16'h0000, cfg_read};
      else if (cwd_hit(haddr, `CWD_CAL_ADDR))  rdata_nxt = {16'h0000, cal_r};
      else if (cwd_hit(haddr, `CWD_STAT_ADDR)) rdata_nxt = {26'h0, st_r, erase_r,
                                                            brownout_reset_en, watchdog_en};
      else                                      rdata_nxt = 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      addr_r  <= 32'h0000_0000;
      wr_r    <= 1'b0;
      rd_r    <= 1'b0;
      cfg_r   <= `CWD_CFG_RESET;
      cal_r   <= `CWD_CAL_RESET;
      rdata_r <= 32'h0000_0000;
    end else begin
      addr_r  <= addr_nxt;
      wr_r    <= wr_nxt;
      rd_r    <= rd_nxt;
      cfg_r   <= cfg_nxt;
      cal_r   <= cal_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign hrdata    = rdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // protection release: the bit goes high as the erase starts, the protect output drops after it
  logic dprot_rise, pprot_rise, rst_evt;
  assign dprot_rise = wr_r && cwd_hit(addr_r, `CWD_CFG_ADDR) && !cfg_r[`CWD_DPROT_BIT]
                      && hwdata[`CWD_DPROT_BIT];
  assign pprot_rise = wr_r && cwd_hit(addr_r, `CWD_CFG_ADDR) && !cfg_r[`CWD_PPROT_BIT]
                      && hwdata[`CWD_PPROT_BIT];
  assign rst_evt    = (evt_s2_r[0] && !por_d_r) || (evt_s2_r[1] && !brn_d_r);

  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    erase_nxt = erase_r;
    case (st_r)
      CWD_ST_IDLE: begin
        if (dprot_rise || pprot_rise) begin
          st_nxt    = CWD_ST_ERASE;
          cnt_nxt   = 32'(`CWD_ERASE_CYC);
          erase_nxt = {pprot_rise, dprot_rise};
        end else if (rst_evt && !cfg_r[`CWD_PUD_BIT]) begin
          st_nxt  = CWD_ST_DELAY;
          cnt_nxt = DELAY_CYC;
        end
      end
      CWD_ST_ERASE: begin
        if (cnt_r <= 32'h1) begin
          st_nxt    = CWD_ST_IDLE;
          erase_nxt = 2'b00;
          cnt_nxt   = 32'h0;
        end else begin
          cnt_nxt = cnt_r - 32'h1;
        end
      end
      CWD_ST_DELAY: begin
        if (rst_evt) cnt_nxt = DELAY_CYC;
        else if (cnt_r <= 32'h1) begin
          st_nxt  = CWD_ST_IDLE;
          cnt_nxt = 32'h0;
        end else begin
          cnt_nxt = cnt_r - 32'h1;
        end
      end
      default: begin
        st_nxt    = CWD_ST_IDLE;
        cnt_nxt   = 32'h0;
        erase_nxt = 2'b00;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_r    <= CWD_ST_IDLE;
      cnt_r   <= 32'h0;
      erase_r <= 2'b00;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      erase_r <= erase_nxt;
    end
  end

  // protection holds until the erase of that memory has finished
  logic dprot_r, pprot_r;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dprot_r <= 1'b0;
      pprot_r <= 1'b0;
    end else begin
      dprot_r <= !cfg_r[`CWD_DPROT_BIT] || erase_r[0] || dprot_rise;
      pprot_r <= !cfg_r[`CWD_PPROT_BIT] || erase_r[1] || pprot_rise;
    end
  end

  cwd_brn_e brn_mode;
  cwd_osc_e osc_mode;
  logic     rst_pin_low;
  assign brn_mode    = cwd_brn_e'(cfg_r[`CWD_BRN_HI:`CWD_BRN_LO]);
  assign osc_mode    = cwd_osc_e'(cfg_r[`CWD_OSC_HI:`CWD_OSC_LO]);
  assign rst_pin_low = cfg_r[`CWD_XRST_BIT] && !pin_s2_r[1];

  always_comb begin
    case (brn_mode)
      CWD_BRN_ON:   brownout_reset_en = 1'b1;
      CWD_BRN_NSLP: brownout_reset_en = !slp_s2_r;
      CWD_BRN_SOFT: brownout_reset_en = brownout_soft_en;
      default:      brownout_reset_en = 1'b0;
    endcase
  end

  always_comb begin
    osc_clkin_used   = 1'b0;
    osc_clkout_drive = 1'b0;
    osc_pins_crystal = 1'b0;
    case (osc_mode)
      CWD_OSC_RC:   begin osc_clkin_used = 1'b1; osc_clkout_drive = 1'b1; end
      CWD_OSC_RCPIN: osc_clkin_used = 1'b1;
      CWD_OSC_INT:  osc_clkout_drive = 1'b1;
      CWD_OSC_IOIO: osc_clkin_used = 1'b0;
      CWD_OSC_EC:   osc_clkin_used = 1'b1;
      CWD_OSC_HS, CWD_OSC_XT, CWD_OSC_LP: begin
        osc_clkin_used   = 1'b1;
        osc_pins_crystal = 1'b1;
      end
      default:      osc_clkin_used = 1'b0;
    endcase
  end

  assign clock_fail_monitor_en = cfg_r[`CWD_FCM_BIT];
  assign clock_switchover_en   = cfg_r[`CWD_SWO_BIT];
  assign data_mem_protect      = dprot_r;
  assign prog_mem_protect      = pprot_r;
  assign data_mem_erase        = erase_r[0];
  assign prog_mem_erase        = erase_r[1];
  assign ext_reset_pin_sel     = cfg_r[`CWD_XRST_BIT];
  assign pin_io_in             = pin_s2_r[0];
  assign chip_reset_n          = !rst_pin_low && (st_r != CWD_ST_DELAY);
  assign powerup_delay_active  = (st_r == CWD_ST_DELAY);
  assign watchdog_en           = cfg_r[`CWD_WDT_BIT] || watchdog_soft_en;
  assign osc_source_sel        = cfg_r[`CWD_OSC_HI:`CWD_OSC_LO];
  assign internal_osc_run      = !(rst_pin_low && (osc_mode == CWD_OSC_INT ||
                                   osc_mode == CWD_OSC_IOIO || osc_mode == CWD_OSC_RC ||
                                   osc_mode == CWD_OSC_RCPIN));
  assign trim_word             = cal_r;

endmodule // cwd_config_word_decoder

// ===== verilog/cwd_map.svh
// How it works
// - bits 15-12 of the configuration word always read back as ones
// - bit 11 high enables the clock fail monitor
// - bit 10 high enables internal/external clock switchover
// - brown-out code 11 always on; 10 on except during sleep
// - brown-out code 01 follows software enable; 00 keeps brown-out off
// - bit 7 low protects data memory against readout
// - bit 6 low protects program memory against readout
// - clearing data protection while idle erases all data memory first; during an erase or delay it releases with no erase
// - clearing program protection while idle erases all program memory before release; during an erase or delay it releases with no erase
// - bit 5 high makes shared pin external reset, else input and reset idle
// - bit 4 low runs the power-up delay timer, high skips it
// - bit 3 high forces watchdog on, else software enable decides
// - codes 111/110 use rc oscillator, clock-out driven only for 111
// - code 101 internal osc with clock-out, 100 both pins are io
// - brown-out mode never enables the power-up delay timer itself
// - external reset in internal or rc mode stops the internal oscillator
// - factory trims come from a calibration word untouched by bulk erase
// - sleep-gated brown-out ignores software enable and returns on wake-up
// - enabled delay timer holds reset 64 ms after power-on or brown-out only; events during an erase or a protection write are dropped
`ifndef CWD_MAP_SVH
`define CWD_MAP_SVH
`define CWD_CFG_ADDR      32'h0000_0000
`define CWD_CAL_ADDR      32'h0000_0004
`define CWD_STAT_ADDR     32'h0000_0008
`define CWD_CTRL_ADDR     32'h0000_000C
`define CWD_CFG_RESET     16'hFFFF
`define CWD_CAL_RESET     16'h0000
`define CWD_UNIMP_MASK    16'hF000
`define CWD_FCM_BIT       11
`define CWD_SWO_BIT       10
`define CWD_BRN_HI        9
`define CWD_BRN_LO        8
`define CWD_DPROT_BIT     7
`define CWD_PPROT_BIT     6
`define CWD_XRST_BIT      5
`define CWD_PUD_BIT       4
`define CWD_WDT_BIT       3
`define CWD_OSC_HI        2
`define CWD_OSC_LO        0
`define CWD_DELAY_MS      64
`define CWD_CLK_KHZ       20000
`define CWD_DELAY_CYC     (`CWD_DELAY_MS * `CWD_CLK_KHZ)
`define CWD_ERASE_CYC     16
`endif

// ===== verilog/cwd_pkg.sv
package cwd_pkg;
  typedef enum logic [2:0] {
    CWD_OSC_LP   = 3'b000,
    CWD_OSC_XT   = 3'b001,
    CWD_OSC_HS   = 3'b010,
    CWD_OSC_EC   = 3'b011,
    CWD_OSC_IOIO = 3'b100,
    CWD_OSC_INT  = 3'b101,
    CWD_OSC_RCPIN = 3'b110,
    CWD_OSC_RC   = 3'b111
  } cwd_osc_e;
  typedef enum logic [1:0] {
    CWD_BRN_OFF   = 2'b00,
    CWD_BRN_SOFT  = 2'b01,
    CWD_BRN_NSLP  = 2'b10,
    CWD_BRN_ON    = 2'b11
  } cwd_brn_e;
  typedef enum logic [1:0] {
    CWD_ST_IDLE  = 2'b00,
    CWD_ST_ERASE = 2'b01,
    CWD_ST_DELAY = 2'b10
  } cwd_state_e;
endpackage

// ===== tb/cwd_properties.sv
`timescale 1ns/10ps
module cwd_checker (
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       watchdog_soft_en,
  input wire logic       watchdog_en,
  input wire logic       ext_reset_pin_sel,
  input wire logic       pin_io_in,
  input wire logic       chip_reset_n,
  input wire logic       powerup_delay_active,
  input wire logic       data_mem_erase,
  input wire logic       data_mem_protect,
  input wire logic       prog_mem_erase,
  input wire logic       prog_mem_protect,
  input wire logic [2:0] osc_source_sel,
  input wire logic       osc_clkout_drive,
  input wire logic       osc_pins_crystal,
  input wire logic       internal_osc_run
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  chk_clkout_code: assert property (osc_clkout_drive == (osc_source_sel inside {3'h7, 3'h5}))
    else $error("clock-out drive does not match oscillator code");
  chk_crystal_code: assert property (osc_pins_crystal == (osc_source_sel < 3'h3))
    else $error("crystal pins do not match oscillator code");
  chk_osc_stop: assert property (ext_reset_pin_sel && !pin_io_in && osc_source_sel[2]
    |-> !internal_osc_run) else $error("internal oscillator runs during pin reset");
  chk_pin_reset: assert property (ext_reset_pin_sel && !pin_io_in |-> !chip_reset_n)
    else $error("pin reset not passed to chip");
  chk_pin_idle: assert property (!ext_reset_pin_sel && !powerup_delay_active |-> chip_reset_n)
    else $error("reset asserted while pin is an input");
  chk_data_erase: assert property ($rose(data_mem_erase) |-> data_mem_erase[*8]
    ##1 data_mem_erase[*8] ##1 !data_mem_erase) else $error("data erase length wrong");
  chk_prog_erase: assert property ($rose(prog_mem_erase) |-> prog_mem_erase[*8]
    ##1 prog_mem_erase[*8] ##1 !prog_mem_erase) else $error("program erase length wrong");
  chk_erase_hold: assert property (data_mem_erase || prog_mem_erase
    |-> (data_mem_protect || !data_mem_erase) && (prog_mem_protect || !prog_mem_erase))
    else $error("protection released during erase");
  chk_wdt_soft: assert property (watchdog_soft_en |-> watchdog_en)
    else $error("software watchdog enable ignored");
endmodule // cwd_checker

bind cwd_config_word_decoder cwd_checker u_chk (.sys_clk, .rstn, .watchdog_soft_en, .watchdog_en,
  .ext_reset_pin_sel, .pin_io_in, .chip_reset_n, .powerup_delay_active, .data_mem_erase,
  .data_mem_protect, .prog_mem_erase, .prog_mem_protect, .osc_source_sel, .osc_clkout_drive,
  .osc_pins_crystal, .internal_osc_run);

// ===== tb/config_word_decoder_tb.sv
`timescale 1ns/10ps
module config_word_decoder_tb;
  logic sys_clk = 0, rstn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd, hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0, osc_source_sel;
  logic ext_reset_in_n = 1, sleep_in = 0, brownout_soft_en = 0, watchdog_soft_en = 0;
  logic por_event = 0, brownout_event = 0;
  logic hreadyout, hresp, clock_fail_monitor_en, clock_switchover_en, brownout_reset_en;
  logic data_mem_protect, prog_mem_protect, data_mem_erase, prog_mem_erase, ext_reset_pin_sel;
  logic chip_reset_n, pin_io_in, powerup_delay_active, watchdog_en, osc_clkin_used;
  logic osc_clkout_drive, osc_pins_crystal, internal_osc_run;
  logic [15:0] trim_word, v;
  int fails = 0, n_checks = 0, cyc = 0, n;

  always #25 sys_clk = ~sys_clk;

  cwd_config_word_decoder #(.DELAY_CYC(20)) u_dut (.sys_clk, .rstn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_reset_in_n,
    .sleep_in, .brownout_soft_en, .watchdog_soft_en, .por_event, .brownout_event,
    .clock_fail_monitor_en, .clock_switchover_en, .brownout_reset_en, .data_mem_protect,
    .prog_mem_protect, .data_mem_erase, .prog_mem_erase, .ext_reset_pin_sel, .chip_reset_n,
    .pin_io_in, .powerup_delay_active, .watchdog_en, .osc_source_sel, .osc_clkin_used,
    .osc_clkout_drive, .osc_pins_crystal, .internal_osc_run, .trim_word);

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  task automatic delay_count();
    n = 0;
    repeat (40) begin
      settle(1);
      n += int'(powerup_delay_active);
    end
  endtask

  function automatic logic brn_exp(input logic [1:0] m);
    case (m)
      2'h3: return 1'b1;
      2'h2: return !sleep_in;
      2'h1: return brownout_soft_en;
      default: return 1'b0;
    endcase
  endfunction

  initial begin
    void'($urandom(7));
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    bus(0, 32'h0, 32'h0);
    chk("cfg reset", rd, 32'h0000FFFF);
    chk("bus resp", {hreadyout, hresp}, 2'h2);
    bus(0, 32'h4, 32'h0);
    chk("cal reset", rd, 32'h00000000);
    bus(1, 32'hC, 32'h00005A5A);
    bus(0, 32'hC, 32'h0);
    chk("unmapped", rd, 32'h00000000);
    for (int i = 0; i < 16; i++) begin
      v = 16'($urandom) | 16'h00C0;
      v[2:0] = i[2:0];
      v[9:8] = i[3:2];
      sleep_in <= 1'($urandom);
      brownout_soft_en <= 1'($urandom);
      watchdog_soft_en <= 1'($urandom);
      bus(1, 32'h0, {16'h0, v});
      bus(0, 32'h0, 32'h0);
      chk("cfg read", rd, {16'h0, 4'hF, v[11:0]});
      settle(3);
      chk("fail monitor", clock_fail_monitor_en, v[11]);
      chk("switchover", clock_switchover_en, v[10]);
      chk("brownout", brownout_reset_en, brn_exp(v[9:8]));
      chk("pin select", ext_reset_pin_sel, v[5]);
      chk("watchdog", watchdog_en, v[3] | watchdog_soft_en);
      chk("osc code", osc_source_sel, v[2:0]);
      chk("clock out", osc_clkout_drive, v[2] & v[0]);
      chk("clock in", osc_clkin_used, !(v[2] & !v[1]));
      chk("crystal", osc_pins_crystal, v[2:0] < 3'h3);
    end
    bus(1, 32'h0, 32'h0000FF3F);
    bus(1, 32'h4, 32'h0000ABCD);
    settle(2);
    chk("data protect", data_mem_protect, 1'b1);
    chk("prog protect", prog_mem_protect, 1'b1);
    chk("trim", trim_word, 16'hABCD);
    bus(1, 32'h0, 32'h0000FFFF);
    settle(2);
    chk("data erase", data_mem_erase, 1'b1);
    chk("prog erase", prog_mem_erase, 1'b1);
    settle(20);
    chk("data free", {data_mem_erase, data_mem_protect}, 2'h0);
    chk("prog free", {prog_mem_erase, prog_mem_protect}, 2'h0);
    chk("trim kept", trim_word, 16'hABCD);
    bus(1, 32'h0, 32'h0000FFFD);
    ext_reset_in_n <= 1'b0;
    settle(4);
    chk("pin reset", chip_reset_n, 1'b0);
    chk("osc stop", internal_osc_run, 1'b0);
    bus(1, 32'h0, 32'h0000FFDD);
    settle(3);
    chk("pin input", {chip_reset_n, pin_io_in, internal_osc_run}, 3'h5);
    ext_reset_in_n <= 1'b1;
    bus(1, 32'h0, 32'h0000FFEF);
    por_event <= 1'b1;
    delay_count();
    chk("delay run", n >= 20 && n <= 24, 1'b1);
    por_event <= 1'b0;
    bus(1, 32'h0, 32'h0000FFFF);
    brownout_event <= 1'b1;
    delay_count();
    chk("delay skip", n, 0);
    close_out();
  end
endmodule // config_word_decoder_tb
